// [core/crs_core.sv]
/*
 * crs_core.sv: card-reader synchronizer control: head-2 buffer transfer
 * completion, output stacker selection and the abnormal-operation latch,
 * with an AHB-Lite register slave.
 * Assumes all inputs are synchronous to i_clk; one-cycle marker pulses.
 */
module crs_core (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [11:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // drum, reader and processor
    input wire crs_pkg::crs_drum_t i_drum,
    input wire crs_pkg::crs_reader_t i_rdr,
    input wire crs_pkg::crs_cpu_t i_cpu,
    // transfer outputs
    output logic o_head2_read_latch_out,
    output logic [7:0] o_dest_loc,
    output logic o_buffer_loaded,
    output logic o_cond_transfer,
    output logic o_ending_pulse,
    output logic o_cond_transfer_clear,
    // stacker outputs
    output logic o_clear_static,
    output logic o_stacker2_actuate,
    output logic o_stacker1_actuate,
    // abnormal outputs
    output logic o_abnormal_latch_out,
    output logic o_abnormal_latch_out_n,
    output logic [2:0] o_off_normal,
    output logic o_reader_off_normal_lamp,
    output logic o_io_abnormal,
    output logic o_card_ending_pulse,
    output logic o_jam_signal_a,
    output logic o_jam_signal_b,
    output logic o_feed_interlock,
    output logic o_move_c_to_a,
    output logic o_search_c_plus_one,
    output logic o_jam_indicator,
    output logic o_bin_full_indicator,
    output logic o_empty_indicator,
    output logic o_jam_relay_ok
);
    import crs_pkg::*;

    crs_state_t s_q;
    crs_state_t s_d;
    logic arm;
    logic permit_low;
    logic gclr;
    logic row_2_to_3;
    logic row_11_to_12;
    logic [31:0] stat_word;

    // abnormal condition gather, latched jam and empty flags count too, bin full only while its switch is made
    assign arm = (i_rdr.card_jam_sw | s_q.jam_indicator) | (|i_rdr.bin_full_sw) | i_rdr.stop_sw
        | s_q.empty_ind | i_rdr.registration_err | s_q.one_card;
    assign permit_low = i_cpu.search_active | i_cpu.processor_stopped;
    assign row_11_to_12 = i_rdr.row_step_pulse & (i_rdr.row_count == `CRS_ROW_11);
    assign row_2_to_3 = i_rdr.row_step_pulse & (i_rdr.row_count == `CRS_ROW_2);
    assign gclr = s_q.wr_pend & (s_q.wr_addr == `CRS_CTRL_OFS) & i_hwdata[`CRS_CTRL_GCLR_BIT];

    // status view of the block's own latches
    always_comb begin
        stat_word = `CRS_RST_WORD;
        stat_word[`CRS_STAT_ABN_BIT] = s_q.abnormal;
        stat_word[`CRS_STAT_IOABN_BIT] = s_q.io_abnormal;
        stat_word[`CRS_STAT_JAMIND_BIT] = s_q.jam_indicator;
        stat_word[`CRS_STAT_BINFULL_BIT] = s_q.bin_full_ind;
        stat_word[`CRS_STAT_EMPTY_BIT] = s_q.empty_ind;
        stat_word[`CRS_STAT_BUFLD_BIT] = s_q.buffer_loaded;
        stat_word[`CRS_STAT_CONDX_BIT] = s_q.cond_transfer;
        stat_word[`CRS_STAT_S2C_BIT] = s_q.stacker2_choice_latch;
        stat_word[`CRS_STAT_S1C_BIT] = s_q.stacker1_choice_latch;
        stat_word[`CRS_STAT_S2A_BIT] = s_q.stacker2_actuate_latch;
        stat_word[`CRS_STAT_S1A_BIT] = s_q.stacker1_actuate_latch;
        stat_word[`CRS_STAT_S1D_BIT] = s_q.stacker1_delay_latch;
        stat_word[`CRS_STAT_JAMRLY_BIT] = s_q.jam_relay_ok;
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.ending_pulse = 1'b0;
        s_d.cond_transfer_clear = 1'b0;
        s_d.clear_static = 1'b0;
        s_d.card_ending_pulse = 1'b0;
        s_d.head2_read = 1'b0;

        // head-2 reads one lower-field word per marker
        if (i_drum.lower_field_transfer_marker && i_drum.buffer_transfer_function_signal
            && i_drum.drum_loc >= `CRS_HEAD2_FIRST_LOC
            && i_drum.drum_loc <= `CRS_HEAD2_LAST_LOC) begin
            s_d.head2_read = 1'b1;
            // first marker targets 102, later ones follow the drum
            s_d.dest_loc = i_drum.drum_loc + 8'd1;
        end

        // end of transfer marker
        if (i_drum.end_of_transfer_marker && i_drum.buffer_transfer_function_signal) begin
            s_d.buffer_loaded = 1'b0;
        end
        if (i_drum.end_of_transfer_marker && i_drum.completion_function_signal) begin
            s_d.ending_pulse = 1'b1;
            s_d.cond_transfer_clear = 1'b1;
            s_d.cond_transfer = 1'b0;
        end
        // loading events win over the clear in the same cycle
        if (i_drum.buffer_loaded_set) begin
            s_d.buffer_loaded = 1'b1;
        end
        if (i_drum.cond_transfer_set) begin
            s_d.cond_transfer = 1'b1;
        end

        // stacker select: store digit, then sample next cycle
        if (i_cpu.stacker_select_staticized && !s_q.sample_pending) begin
            s_d.multiplier_quotient_counter = i_cpu.digit7;
            s_d.sample_pending = 1'b1;
        end
        if (s_q.sample_pending) begin
            // choice latches restored first, then the digit decides
            s_d.stacker2_choice_latch = (s_q.multiplier_quotient_counter == 4'd2);
            s_d.stacker1_choice_latch = (s_q.multiplier_quotient_counter == 4'd1);
            s_d.sample_pending = 1'b0;
            s_d.clear_static = 1'b1;
        end
        // otherwise choices simply hold across cards

        // stacker 2 actuation window
        if (s_q.stacker2_actuate_latch && row_2_to_3) begin
            s_d.stacker2_actuate_latch = 1'b0;
        end
        if (i_rdr.card_to_stackers_stage && row_11_to_12 && s_q.stacker2_choice_latch) begin
            s_d.stacker2_actuate_latch = 1'b1;
        end
        // stacker 1 is farther, so the selector waits for row 8
        if (s_q.stacker1_actuate_latch && row_2_to_3) begin
            s_d.stacker1_actuate_latch = 1'b0;
        end
        if (i_rdr.card_to_stackers_stage && row_11_to_12 && s_q.stacker1_choice_latch) begin
            s_d.stacker1_delay_latch = 1'b1;
        end
        if (s_q.stacker1_delay_latch && i_rdr.row_count == `CRS_ROW_8) begin
            s_d.stacker1_actuate_latch = 1'b1;
            s_d.stacker1_delay_latch = 1'b0;
        end
        // digit zero: no choice set, nothing raised, stacker 0 catches

        // clears come first so that a set in the same cycle wins
        if (s_q.wr_pend && s_q.wr_addr == `CRS_XFER_OFS) begin
            s_d.feed_interlock = 1'b0;
        end
        // general clear wipes every abnormal effect at once except jam_relay_ok, which needs the jam reset bit
        if (gclr) begin
            s_d.abnormal = 1'b0;
            s_d.io_abnormal = 1'b0;
            s_d.jam_signal_a = 1'b0;
            s_d.jam_signal_b = 1'b0;
            s_d.move_c_to_a = 1'b0;
            s_d.search_c_plus_one = 1'b0;
            s_d.jam_indicator = 1'b0;
            s_d.bin_full_ind = 1'b0;
            s_d.empty_ind = 1'b0;
            s_d.empty_wait = 1'b0;
        end

        // fault indicators
        if (i_rdr.card_jam_sw) begin
            s_d.jam_indicator = 1'b1;
            s_d.jam_relay_ok = 1'b0;
        end
        if (|i_rdr.bin_full_sw) begin
            s_d.bin_full_ind = 1'b1;
        end
        // empty bin: a card must close the switch before row 1
        if (i_cpu.card_cycle_function_signal && i_rdr.card_fed_window) begin
            s_d.empty_wait = 1'b1;
        end
        if (i_rdr.empty_bin_sw) begin
            s_d.empty_wait = 1'b0;
        end
        if (s_q.empty_wait && !i_rdr.empty_bin_sw && i_rdr.row_count == `CRS_ROW_1) begin
            s_d.empty_ind = 1'b1;
            s_d.empty_wait = 1'b0;
        end

        // abnormal latch sets only with the permit low
        if (arm && permit_low) begin
            s_d.abnormal = 1'b1;
        end

        // card-cycle instruction handling
        if (i_cpu.card_cycle_function_signal && !s_q.io_abnormal) begin
            if (s_q.abnormal) begin
                s_d.io_abnormal = 1'b1;
            end else begin
                s_d.card_ending_pulse = 1'b1;
            end
        end
        if (s_q.io_abnormal && i_cpu.t10b) begin
            s_d.jam_signal_a = 1'b1;
            s_d.jam_signal_b = 1'b1;
            s_d.move_c_to_a = 1'b1;
            s_d.search_c_plus_one = 1'b1;
        end
        // jam signal b blocks the pickerknife interlock
        if (i_cpu.card_cycle_function_signal && i_cpu.t11b && !s_q.jam_signal_b
            && !s_q.abnormal) begin
            s_d.feed_interlock = 1'b1;
        end

        // register bus write data phase
        s_d.hready = 1'b1;
        if (s_q.wr_pend && s_q.wr_addr == `CRS_CTRL_OFS) begin
            if (i_hwdata[`CRS_CTRL_JAMRST_BIT] && !i_rdr.card_jam_sw) begin
                s_d.jam_relay_ok = 1'b1;
            end
            s_d.one_card = i_hwdata[`CRS_CTRL_ONECARD_BIT];
        end

        // address phase capture; zero wait state
        s_d.wr_pend = 1'b0;
        if (i_hsel && i_hready && i_htrans[1]) begin
            s_d.wr_pend = i_hwrite;
            s_d.wr_addr = {i_haddr[11:2], 2'b00};
            if (!i_hwrite) begin
                unique case ({i_haddr[11:2], 2'b00})
                    `CRS_CTRL_OFS: s_d.hrdata = {29'd0, s_q.one_card, 2'b00};
                    `CRS_STAT_OFS: s_d.hrdata = stat_word;
                    `CRS_STKSEL_OFS: s_d.hrdata = {28'd0, s_q.multiplier_quotient_counter};
                    `CRS_XFER_OFS: s_d.hrdata = {16'd0, s_q.dest_loc, 7'd0, s_q.feed_interlock};
                    default: s_d.hrdata = `CRS_RST_WORD; // unmapped reads as zero
                endcase
            end
        end
    end

    // single register of all state
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '0;
            s_q.jam_relay_ok <= 1'b1;
            s_q.hready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops, o_hresp tied low
    assign o_hreadyout = s_q.hready;
    assign o_hresp = 1'b0;
    assign o_hrdata = s_q.hrdata;
    assign o_head2_read_latch_out = s_q.head2_read;
    assign o_dest_loc = s_q.dest_loc;
    assign o_buffer_loaded = s_q.buffer_loaded;
    assign o_cond_transfer = s_q.cond_transfer;
    assign o_ending_pulse = s_q.ending_pulse;
    assign o_cond_transfer_clear = s_q.cond_transfer_clear;
    assign o_clear_static = s_q.clear_static;
    assign o_stacker2_actuate = s_q.stacker2_actuate_latch;
    assign o_stacker1_actuate = s_q.stacker1_actuate_latch;
    // complementary pair and lamps
    assign o_abnormal_latch_out = s_q.abnormal;
    assign o_abnormal_latch_out_n = ~s_q.abnormal;
    assign o_off_normal = {3{s_q.abnormal}};
    assign o_reader_off_normal_lamp = s_q.abnormal;
    assign o_io_abnormal = s_q.io_abnormal;
    assign o_card_ending_pulse = s_q.card_ending_pulse;
    assign o_jam_signal_a = s_q.jam_signal_a;
    assign o_jam_signal_b = s_q.jam_signal_b;
    assign o_feed_interlock = s_q.feed_interlock;
    assign o_move_c_to_a = s_q.move_c_to_a;
    assign o_search_c_plus_one = s_q.search_c_plus_one;
    assign o_jam_indicator = s_q.jam_indicator;
    assign o_bin_full_indicator = s_q.bin_full_ind;
    assign o_empty_indicator = s_q.empty_ind;
    assign o_jam_relay_ok = s_q.jam_relay_ok;
endmodule : crs_core

// [core/crs_pkg.sv]
/*
 * crs_pkg.sv: types shared by the card-reader synchronizer block.
 * Assumes crs_regs.svh lies on the include path.
 */
package crs_pkg;
    `include "crs_regs.svh"

    // drum transfer side signals
    typedef struct packed {
        logic lower_field_transfer_marker;
        logic end_of_transfer_marker;
        logic buffer_transfer_function_signal;
        logic completion_function_signal;
        logic [7:0] drum_loc;
        logic buffer_loaded_set;
        logic cond_transfer_set;
    } crs_drum_t;

    // reader mechanics signals
    typedef struct packed {
        logic card_to_stackers_stage;
        logic row_step_pulse;
        logic [3:0] row_count;
        logic card_jam_sw;
        logic [2:0] bin_full_sw;
        logic stop_sw;
        logic empty_bin_sw;
        logic registration_err;
        logic card_fed_window;
    } crs_reader_t;

    // processor side signals
    typedef struct packed {
        logic search_active;
        logic processor_stopped;
        logic stacker_select_staticized;
        logic [3:0] digit7;
        logic card_cycle_function_signal;
        logic t10b;
        logic t11b;
    } crs_cpu_t;

    // all block state
    typedef struct packed {
        logic head2_read;
        logic [7:0] dest_loc;
        logic buffer_loaded;
        logic cond_transfer;
        logic ending_pulse;
        logic cond_transfer_clear;
        logic [3:0] multiplier_quotient_counter;
        logic sample_pending;
        logic clear_static;
        logic stacker2_choice_latch;
        logic stacker1_choice_latch;
        logic stacker2_actuate_latch;
        logic stacker1_actuate_latch;
        logic stacker1_delay_latch;
        logic abnormal;
        logic io_abnormal;
        logic jam_indicator;
        logic bin_full_ind;
        logic empty_ind;
        logic empty_wait;
        logic jam_relay_ok;
        logic one_card;
        logic card_ending_pulse;
        logic jam_signal_a;
        logic jam_signal_b;
        logic feed_interlock;
        logic move_c_to_a;
        logic search_c_plus_one;
        logic hready;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [11:0] wr_addr;
    } crs_state_t;
endpackage : crs_pkg

// [core/crs_regs.svh]
/*
 * crs_regs.svh: register map, field positions, reset values and timing
 * counts for the card-reader synchronizer control block.
 * Assumes it is included by its bare name from the package and the bench.
 */
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

// register byte offsets
`define CRS_CTRL_OFS 12'h000
`define CRS_STAT_OFS 12'h004
`define CRS_STKSEL_OFS 12'h008
`define CRS_XFER_OFS 12'h00C

// control register fields
`define CRS_CTRL_GCLR_BIT 0
`define CRS_CTRL_JAMRST_BIT 1
`define CRS_CTRL_ONECARD_BIT 2

// status register fields
`define CRS_STAT_ABN_BIT 0
`define CRS_STAT_IOABN_BIT 1
`define CRS_STAT_JAMIND_BIT 2
`define CRS_STAT_BINFULL_BIT 3
`define CRS_STAT_EMPTY_BIT 4
`define CRS_STAT_BUFLD_BIT 5
`define CRS_STAT_CONDX_BIT 6
`define CRS_STAT_S2C_BIT 7
`define CRS_STAT_S1C_BIT 8
`define CRS_STAT_S2A_BIT 9
`define CRS_STAT_S1A_BIT 10
`define CRS_STAT_S1D_BIT 11
`define CRS_STAT_JAMRLY_BIT 12

// buffer geometry and row counter values
`define CRS_HEAD2_FIRST_LOC 8'd101
`define CRS_HEAD2_LAST_LOC 8'd196
`define CRS_HEAD2_DEST_FIRST 8'd102
`define CRS_ROW_11 4'd11
`define CRS_ROW_2 4'd2
`define CRS_ROW_8 4'd8
`define CRS_ROW_1 4'd1

// reset values
`define CRS_RST_WORD 32'h0000_0000

`endif

// [test/card_reader_stacker_abnormal_ctrl_bench.sv]
/* bench for crs_core: transfer, stacker choice and abnormal latch.
   assumes the drum model and checker are compiled first. */
`include "crs_regs.svh"
module card_reader_stacker_abnormal_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import crs_pkg::*;
    logic i_clk = 0, i_sys_rst = 1, i_hsel = 0, i_hwrite = 0, go = 0, slow = 0, busy;
    logic [11:0] i_haddr = '0;
    logic [1:0] i_htrans = '0;
    logic [2:0] i_hsize = 3'h2;
    logic [31:0] i_hwdata = '0, o_hrdata, rd, lfsr = 32'h0000_928e;
    crs_drum_t i_drum;
    crs_reader_t i_rdr = '0;
    crs_cpu_t i_cpu = '0;
    logic o_hreadyout, o_hresp, o_head2_read_latch_out, o_buffer_loaded, o_cond_transfer;
    logic o_ending_pulse, o_cond_transfer_clear, o_clear_static, o_stacker2_actuate;
    logic o_stacker1_actuate, o_abnormal_latch_out, o_abnormal_latch_out_n, o_io_abnormal;
    logic o_reader_off_normal_lamp, o_card_ending_pulse, o_jam_signal_a, o_jam_signal_b;
    logic o_feed_interlock, o_move_c_to_a, o_search_c_plus_one, o_jam_indicator;
    logic o_bin_full_indicator, o_empty_indicator, o_jam_relay_ok;
    logic [7:0] o_dest_loc;
    logic [2:0] o_off_normal;
    int error_cnt = 0, comparisons = 0, cyc = 0, h2 = 0, epc = 0, cep = 0;
    int ch = 0, e1 = 0, e2 = 0, ed = 0;
    crs_core uut (.i_hready(o_hreadyout), .*);
    crs_drum_model drum (.i_clk, .i_sys_rst, .i_go(go), .i_slow(slow), .o_drum(i_drum),
        .o_busy(busy));
    initial forever #10 i_clk = ~i_clk;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    task wrap_up;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    // master waits for hready at each phase, no fixed latency assumed
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        i_hsel <= 1;
        i_htrans <= 2'b10;
        i_haddr <= a;
        i_hwrite <= w;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_hsel <= 0;
        i_htrans <= 2'b00;
        i_hwdata <= d;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
    endtask : ahb
    // pulse counters and hang guard
    always @(posedge i_clk) begin
        cyc++;
        h2 += (o_head2_read_latch_out === 1'b1);
        epc += (o_ending_pulse === 1'b1);
        cep += (o_card_ending_pulse === 1'b1);
        if (cyc == 10000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic xfer(input logic s);
        h2 = 0;
        epc = 0;
        slow <= s;
        go <= 1;
        tick(1);
        go <= 0;
        while (h2 == 0) @(posedge i_clk);
        chk("dest first", o_dest_loc, 102);
        chk("loaded", {o_buffer_loaded, o_cond_transfer}, 2'b11);
        while (busy !== 1'b0) @(posedge i_clk);
        tick(3);
        chk("head2 count", h2, (196 - 101) / 5 + 1);
        chk("ending", epc, 1);
        chk("loaded end", {o_buffer_loaded, o_cond_transfer}, 2'b00);
        ahb(0, `CRS_XFER_OFS, 0);
        chk("dest reg", rd[15:8], 197);
    endtask : xfer
    task automatic sel(input int d);
        int cs = 0;
        i_cpu.stacker_select_staticized <= 1;
        i_cpu.digit7 <= 4'(d);
        tick(1);
        i_cpu.stacker_select_staticized <= 0;
        repeat (5) begin
            tick(1);
            cs += (o_clear_static === 1'b1);
        end
        chk("clear static", cs, 1);
        ch = d;
        ahb(0, `CRS_STKSEL_OFS, 0);
        chk("digit", rd, d);
        ahb(0, `CRS_STAT_OFS, 0);
        chk("choice", rd[8:7], {d == 1, d == 2});
    endtask : sel
    // row counter steps every four cycles; model tracks the three latches
    task automatic rows(input int n, input int s);
        int r;
        i_rdr.card_to_stackers_stage <= s[0];
        repeat (n) begin
            r = i_rdr.row_count;
            i_rdr.row_step_pulse <= 1;
            tick(1);
            i_rdr.row_step_pulse <= 0;
            i_rdr.row_count <= 4'(r % 12 + 1);
            if (r == 11 && s == 1 && ch == 2) e2 = 1;
            if (r == 11 && s == 1 && ch == 1) ed = 1;
            if (r == 2) e1 = 0;
            if (r == 2) e2 = 0;
            if (r % 12 + 1 == 8 && ed == 1) e1 = 1;
            if (r % 12 + 1 == 8) ed = 0;
            tick(3);
            chk("act2", o_stacker2_actuate, e2);
            chk("act1", o_stacker1_actuate, e1);
        end
    endtask : rows
    task ccyc;
        i_cpu.card_cycle_function_signal <= 1;
        tick(1);
        i_cpu.t10b <= 1;
        tick(1);
        i_cpu.t10b <= 0;
        i_cpu.t11b <= 1;
        tick(1);
        i_cpu.t11b <= 0;
        i_cpu.card_cycle_function_signal <= 0;
        tick(2);
    endtask : ccyc
    task automatic abn(input int k);
        case (k)
            0: i_rdr.card_jam_sw <= 1;
            1: i_rdr.bin_full_sw <= 3'(1 << (lfsr % 3));
            2: i_rdr.stop_sw <= 1;
            3: i_rdr.registration_err <= 1;
            4: ahb(1, `CRS_CTRL_OFS, 32'h0000_0004);
            default: begin
                cep = 0;
                i_rdr.card_fed_window <= 1;
                ccyc();
                chk("card end", {cep != 0, o_feed_interlock}, 2'b11);
                ahb(1, `CRS_XFER_OFS, 0);
                i_rdr.row_count <= 1;
                tick(3);
                i_rdr.row_count <= 3;
            end
        endcase
        lfsr = nxt(lfsr);
        tick(4);
        chk("abn idle", o_abnormal_latch_out, 0);
        if (k % 2) i_cpu.processor_stopped <= 1;
        else i_cpu.search_active <= 1;
        tick(3);
        chk("abn set", o_abnormal_latch_out, 1);
        i_rdr <= '{row_count: 4'd3, default: '0};
        i_cpu.processor_stopped <= 0;
        i_cpu.search_active <= 0;
        tick(3);
        chk("abn out", {o_abnormal_latch_out, o_abnormal_latch_out_n, o_reader_off_normal_lamp,
            o_off_normal}, 6'b10_1111);
        chk("ind", {o_jam_indicator, o_bin_full_indicator, o_empty_indicator},
            {k == 0, k == 1, k == 5});
        cep = 0;
        ccyc();
        chk("jam", {cep != 0, o_io_abnormal, o_jam_signal_a, o_jam_signal_b, o_move_c_to_a,
            o_search_c_plus_one, o_feed_interlock}, 7'b011_1110);
        if (k == 0) begin
            chk("relay", o_jam_relay_ok, 0);
            ahb(1, `CRS_CTRL_OFS, 32'h0000_0002);
            tick(2);
            chk("relay back", o_jam_relay_ok, 1);
        end
        ahb(1, `CRS_CTRL_OFS, 32'h0000_0001);
        tick(2);
        chk("cleared", {o_abnormal_latch_out, o_jam_signal_b}, 2'b00);
    endtask : abn
    // main sequence
    initial begin
        tick(2);
        i_sys_rst <= 0;
        tick(1);
        chk("reset", {o_hreadyout, o_hresp, o_abnormal_latch_out_n, o_jam_relay_ok}, 4'b1011);
        ahb(0, `CRS_STAT_OFS, 0);
        chk("stat reset", rd, 32'h0000_1000);
        ahb(1, 12'h010, 32'hffff_ffff);
        ahb(0, 12'h010, 0);
        chk("unmapped", rd, 0);
        xfer(0);
        xfer(1);
        i_rdr.row_count <= 3;
        for (int i = 0; i < 6; i++) begin
            sel(i < 3 ? 2 - i : lfsr % 3);
            lfsr = nxt(lfsr);
            rows(29, 1);
            rows(7, 0);
        end
        for (int k = 0; k < 6; k++) abn(k);
        wrap_up();
    end
endmodule : card_reader_stacker_abnormal_ctrl_bench

// [test/crs_core_asserts.sv]
/* crs_core_asserts.sv: temporal checks on the crs_core ports, bound in.
   assumes one i_clk domain and i_sys_rst active high. */
module crs_core_chk (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // watched inputs
    input wire crs_pkg::crs_drum_t i_drum,
    input wire crs_pkg::crs_reader_t i_rdr,
    input wire crs_pkg::crs_cpu_t i_cpu,
    // watched outputs
    input wire logic o_head2_read_latch_out,
    input wire logic [7:0] o_dest_loc,
    input wire logic o_buffer_loaded,
    input wire logic o_cond_transfer,
    input wire logic o_ending_pulse,
    input wire logic o_cond_transfer_clear,
    input wire logic o_stacker2_actuate,
    input wire logic o_stacker1_actuate,
    input wire logic o_abnormal_latch_out,
    input wire logic o_abnormal_latch_out_n,
    input wire logic [2:0] o_off_normal,
    input wire logic o_reader_off_normal_lamp,
    input wire logic o_card_ending_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    import crs_pkg::*;
    logic hit;
    logic arm;
    logic eot;
    // marker inside the lower-field window; faults seen on the pins
    assign hit = i_drum.lower_field_transfer_marker && i_drum.buffer_transfer_function_signal
        && i_drum.drum_loc >= 8'd101 && i_drum.drum_loc <= 8'd196;
    assign arm = i_rdr.card_jam_sw || (|i_rdr.bin_full_sw) || i_rdr.stop_sw
        || i_rdr.registration_err;
    assign eot = i_drum.end_of_transfer_marker;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    head2_pulse_a: assert property (hit |=> o_head2_read_latch_out
        && o_dest_loc == $past(i_drum.drum_loc) + 8'd1) else $error("head2 pulse wrong");
    buf_clear_a: assert property (eot && i_drum.buffer_transfer_function_signal
        && !i_drum.buffer_loaded_set |=> !o_buffer_loaded) else $error("loaded kept");
    end_pulse_a: assert property (eot && i_drum.completion_function_signal
        && !i_drum.cond_transfer_set |=> o_ending_pulse && o_cond_transfer_clear
        && !o_cond_transfer) else $error("no ending pulse");
    act2_set_a: assert property ($rose(o_stacker2_actuate) |-> $past(i_rdr.row_step_pulse
        && i_rdr.row_count == 4'd11 && i_rdr.card_to_stackers_stage)) else $error("act2 early");
    act_clear_a: assert property (i_rdr.row_step_pulse && i_rdr.row_count == 4'd2
        |=> !o_stacker2_actuate && !o_stacker1_actuate) else $error("actuate kept");
    act1_set_a: assert property ($rose(o_stacker1_actuate)
        |-> $past(i_rdr.row_count) == 4'd8) else $error("act1 off row");
    abn_out_a: assert property (o_abnormal_latch_out_n == !o_abnormal_latch_out
        && o_off_normal == {3{o_abnormal_latch_out}}
        && o_reader_off_normal_lamp == o_abnormal_latch_out) else $error("abn outputs");
    abn_set_a: assert property (arm && (i_cpu.search_active
        || i_cpu.processor_stopped) |=> o_abnormal_latch_out) else $error("abn not set");
    abn_permit_a: assert property (!o_abnormal_latch_out && !i_cpu.search_active
        && !i_cpu.processor_stopped |=> !o_abnormal_latch_out) else $error("abn set early");
    card_block_a: assert property (i_cpu.card_cycle_function_signal
        && o_abnormal_latch_out |=> !o_card_ending_pulse) else $error("ending not blocked");
    // main scenarios
    cover property (hit);
    cover property ($rose(o_stacker2_actuate));
    cover property ($rose(o_stacker1_actuate));
    cover property ($rose(o_abnormal_latch_out));
endmodule : crs_core_chk
bind crs_core crs_core_chk u_chk (.*);

// [test/crs_drum_model.sv]
/* crs_drum_model.sv: drum sentinel source for the head-2 transfer.
   assumes one clock per drum slot, four clocks per slot when i_slow is high. */
module crs_drum_model (
    // clock, reset and control
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_go,
    input wire logic i_slow,
    // drum side
    output crs_pkg::crs_drum_t o_drum,
    output logic o_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    import crs_pkg::*;
    int loc;
    int hold;
    initial o_drum = '0;
    initial o_busy = 0;
    // idle location lines wander so a stale value is never trusted
    always @(posedge i_clk) begin
        o_drum <= '0;
        o_drum.drum_loc <= ~o_drum.drum_loc;
        if (i_sys_rst) begin
            o_busy <= 0;
        end else if (!o_busy && i_go) begin
            o_busy <= 1;
            loc <= 100;
            hold <= 0;
            o_drum.buffer_loaded_set <= 1;
            o_drum.cond_transfer_set <= 1;
        end else if (o_busy) begin
            o_drum.drum_loc <= loc[7:0];
            o_drum.buffer_transfer_function_signal <= 1;
            hold <= (hold > 0) ? hold - 1 : (i_slow ? 3 : 0);
            if (hold == 0) begin
                loc <= loc + 1;
                // lower-field words every fifth slot, 101 to 196
                o_drum.lower_field_transfer_marker <= loc >= 101 && loc <= 196
                    && loc % 5 == 1;
                if (loc == 200) begin
                    o_drum.end_of_transfer_marker <= 1;
                    o_drum.completion_function_signal <= 1;
                    o_busy <= 0;
                end
            end
        end
    end
endmodule : crs_drum_model
